// file: core/nvmc_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Duration field 00/01/10/11 selects 2, 4, 8 or 16 ms erase/write time.
// - Erase arm enables erase; hardware clears it at erase end.
// - Erase start launches erase, reads high while running, clears at end.
// - Erase start is ignored unless erase arm was already set.
// - Write arm enables write; hardware clears it at write end.
// - Write start launches write and clears when the write finishes.
// - Write start is ignored unless write arm was already set.
// - Read arm enables reads and is never cleared by hardware.
// - Read start launches a read and clears when the read finishes.
// - Read start is ignored unless read arm was already set.
// - A launched cycle stalls the processor until it ends.
// - After the cycle the processor resumes where it stalled.
// - Erase clears the 16-word page chosen by address bit 4 only.
// - After erase every word of the page reads zero.
// - Write stores the four data words into the unit at address bits 4..2.
// - A read puts the word in data pair 0 until the next read or a bus write to that pair.
// - Storage is 32 words of 15 bits under a 5-bit address.
module nvmc_ctrl
	import nvmc_pkg::*;
#(
	parameter int TICK_LEN = nvmc_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nvmc_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpu_stall
);
	import nvmc_pkg::*;

	logic [WORD_W-1:0] mem [DEPTH];
	logic [1:0] program_time_sel, next_program_time_sel;
	logic erase_arm, next_erase_arm;
	logic write_arm, next_write_arm;
	logic read_arm, next_read_arm;
	logic erase_fresh, next_erase_fresh;
	logic write_fresh, next_write_fresh;
	logic [ADDR_W-1:0] nvm_address, next_nvm_address;
	logic [LO_W-1:0] data_lo [NUM_DATA];
	logic [LO_W-1:0] next_data_lo [NUM_DATA];
	logic [HI_W-1:0] data_hi [NUM_DATA];
	logic [HI_W-1:0] next_data_hi [NUM_DATA];
	nvmc_state_type state, next_state;
	logic busy_d;
	logic [31:0] next_prdata;
	logic xfer, wr, dec_ctrl, dec_addr, mapped;
	logic [NUM_DATA-1:0] dec_lo, dec_hi;
	logic launch_erase, launch_write, launch_read, launch_prog;
	logic [TICKS_W-1:0] load_value;
	logic tick, step, done;
	logic [7:0] control_view;

	// ==========================================================
	// Address decode and the read view of every register.
	always_comb begin
		dec_ctrl = (paddr == OFF_CONTROL);
		dec_addr = (paddr == OFF_ADDRESS);
		for (int i = 0; i < NUM_DATA; i++) begin
			dec_lo[i] = (paddr == PADDR_W'(OFF_DATA_BASE + DATA_STRIDE * i));
			dec_hi[i] = (paddr == PADDR_W'(OFF_DATA_BASE + DATA_STRIDE * i + DATA_HI_STEP));
		end
		mapped = dec_ctrl || dec_addr || (|dec_lo) || (|dec_hi);
		// Start bits are the running state itself, so they read high exactly while busy.
		control_view = {program_time_sel, erase_arm, state == ST_ERASE, write_arm,
			state == ST_WRITE, read_arm, state == ST_READ};
		next_prdata = 32'h0;
		if (dec_ctrl) begin
			next_prdata = {24'h0, control_view};
		end
		if (dec_addr) begin
			next_prdata = {27'h0, nvm_address};
		end
		for (int i = 0; i < NUM_DATA; i++) begin
			if (dec_lo[i]) begin
				next_prdata = {24'h0, data_lo[i]};
			end
			if (dec_hi[i]) begin
				next_prdata = {25'h0, data_hi[i]};
			end
		end
	end

	// ==========================================================
	// Bus handshake. The access waits one extra cycle after a cycle ends so that
	// prdata is refreshed from the registers the cycle has just updated.
	assign cpu_stall = (state != ST_IDLE) || busy_d;
	assign pready = !cpu_stall;
	assign pslverr = psel && penable && pready && !mapped;
	assign xfer = psel && penable && pready;
	assign wr = xfer && pwrite && mapped;

	// ==========================================================
	// Launch decisions: the arm bit must already be set, stay set in the
	// same write, and for erase and write have been set by the previous access.
	always_comb begin
		launch_erase = wr && dec_ctrl && pwdata[BIT_ERASE_START] && pwdata[BIT_ERASE_ARM]
			&& erase_arm && erase_fresh;
		launch_write = wr && dec_ctrl && pwdata[BIT_WRITE_START] && pwdata[BIT_WRITE_ARM]
			&& write_arm && write_fresh && !launch_erase;
		launch_read = wr && dec_ctrl && pwdata[BIT_READ_START] && pwdata[BIT_READ_ARM]
			&& read_arm && !launch_erase && !launch_write;
		launch_prog = launch_erase || launch_write;
		// Program length in 1 ms ticks is the base time doubled per code step.
		load_value = TICKS_W'(PROG_BASE_MS) << pwdata[BIT_SEL_HI:BIT_SEL_LO];
		if (launch_read) begin
			load_value = TICKS_W'(READ_CYCLES);
		end
	end

	assign step = (state == ST_READ) ? 1'b1 : tick;

	nvmc_tick_div #(
		.CYCLES(TICK_LEN)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.restart(launch_prog),
		.tick(tick)
	);

	nvmc_timer #(
		.W(TICKS_W)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(launch_prog || launch_read),
		.load_value(load_value),
		.step(step),
		.done(done)
	);

	// ==========================================================
	// Next values for the register file and the cycle state machine.
	always_comb begin
		next_program_time_sel = program_time_sel;
		next_erase_arm = erase_arm;
		next_write_arm = write_arm;
		next_read_arm = read_arm;
		next_erase_fresh = erase_fresh;
		next_write_fresh = write_fresh;
		next_nvm_address = nvm_address;
		next_data_lo = data_lo;
		next_data_hi = data_hi;
		next_state = state;
		if (xfer) begin
			next_erase_fresh = wr && dec_ctrl && pwdata[BIT_ERASE_ARM];
			next_write_fresh = wr && dec_ctrl && pwdata[BIT_WRITE_ARM];
		end
		if (wr && dec_ctrl) begin
			next_program_time_sel = pwdata[BIT_SEL_HI:BIT_SEL_LO];
			next_erase_arm = pwdata[BIT_ERASE_ARM];
			next_write_arm = pwdata[BIT_WRITE_ARM];
			next_read_arm = pwdata[BIT_READ_ARM];
		end
		if (wr && dec_addr) begin
			next_nvm_address = pwdata[ADDR_W-1:0];
		end
		for (int i = 0; i < NUM_DATA; i++) begin
			if (wr && dec_lo[i]) begin
				next_data_lo[i] = pwdata[LO_W-1:0];
			end
			if (wr && dec_hi[i]) begin
				next_data_hi[i] = pwdata[HI_W-1:0];
			end
		end
		case (state)
			ST_IDLE: begin
				if (launch_erase) begin
					next_state = ST_ERASE;
				end else if (launch_write) begin
					next_state = ST_WRITE;
				end else if (launch_read) begin
					next_state = ST_READ;
				end
			end
			ST_ERASE: begin
				if (done) begin
					next_state = ST_IDLE;
					next_erase_arm = 1'b0;
				end
			end
			ST_WRITE: begin
				if (done) begin
					next_state = ST_IDLE;
					next_write_arm = 1'b0;
				end
			end
			ST_READ: begin
				if (done) begin
					next_state = ST_IDLE;
					next_data_lo[0] = mem[nvm_address][LO_W-1:0];
					next_data_hi[0] = mem[nvm_address][WORD_W-1:LO_W];
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{program_time_sel, erase_arm, write_arm, read_arm} <= '0;
			erase_fresh <= 1'b0;
			write_fresh <= 1'b0;
			nvm_address <= '0;
			data_lo <= '{default: '0};
			data_hi <= '{default: '0};
			state <= ST_IDLE;
			busy_d <= 1'b0;
			prdata <= 32'h0;
		end else begin
			program_time_sel <= next_program_time_sel;
			erase_arm <= next_erase_arm;
			write_arm <= next_write_arm;
			read_arm <= next_read_arm;
			erase_fresh <= next_erase_fresh;
			write_fresh <= next_write_fresh;
			nvm_address <= next_nvm_address;
			data_lo <= next_data_lo;
			data_hi <= next_data_hi;
			state <= next_state;
			busy_d <= (state != ST_IDLE);
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// Storage array. It has no reset because its contents are meant to persist.
	always_ff @(posedge pclk) begin
		if (done && state == ST_ERASE) begin
			for (int i = 0; i < 2 ** PAGE_BITS; i++) begin
				mem[{nvm_address[ADDR_W-1], PAGE_BITS'(i)}] <= '0;
			end
		end
		if (done && state == ST_WRITE) begin
			for (int i = 0; i < NUM_DATA; i++) begin
				mem[{nvm_address[ADDR_W-1:UNIT_BITS], UNIT_BITS'(i)}] <=
					{data_hi[i], data_lo[i]};
			end
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_read_run;
		(state == ST_READ)[*2] ##1 (state == ST_IDLE);
	endsequence

	sequence s_resume;
		busy_d && state == ST_IDLE ##1 pready;
	endsequence

	a_erase_needs_arm: assert property (
		(state == ST_IDLE && wr && dec_ctrl && pwdata[BIT_ERASE_START] && !erase_arm)
		|=> state != ST_ERASE) else $error("erase launched without arm");
	a_write_needs_arm: assert property (
		(state == ST_IDLE && wr && dec_ctrl && pwdata[BIT_WRITE_START] && !write_arm)
		|=> state != ST_WRITE) else $error("write launched without arm");
	a_read_needs_arm: assert property (
		(state == ST_IDLE && wr && dec_ctrl && pwdata[BIT_READ_START] && !read_arm)
		|=> state != ST_READ) else $error("read launched without arm");
	a_prog_ticks: assert property (
		launch_prog |-> load_value == (TICKS_W'(2) << pwdata[BIT_SEL_HI:BIT_SEL_LO]))
		else $error("program length does not follow selection");
	a_erase_arm_clear: assert property (
		(state == ST_ERASE && done) |=> !erase_arm && state == ST_IDLE)
		else $error("erase arm not cleared at erase end");
	a_write_arm_clear: assert property (
		(state == ST_WRITE && done) |=> !write_arm && control_view[BIT_WRITE_START] == 1'b0)
		else $error("write arm or start not cleared at write end");
	a_read_length: assert property (
		launch_read |=> s_read_run) else $error("read cycle length wrong");
	a_read_arm_kept: assert property (
		(state == ST_READ && done && read_arm) |=> read_arm)
		else $error("read arm cleared by hardware");
	a_stall_busy: assert property (
		(state != ST_IDLE) |-> !pready && cpu_stall) else $error("bus not stalled while busy");
	a_bus_resume: assert property (
		(state != ST_IDLE) ##1 (state == ST_IDLE) |-> s_resume)
		else $error("processor not released after cycle");
	a_erase_zero: assert property (
		(state == ST_ERASE && done) |=> mem[{nvm_address[ADDR_W-1], PAGE_BITS'(0)}] == '0)
		else $error("erased page not zero");
	a_write_store: assert property (
		(state == ST_WRITE && done) |=> mem[{nvm_address[ADDR_W-1:UNIT_BITS], UNIT_BITS'(3)}]
		== {data_hi[3], data_lo[3]}) else $error("write unit not stored");
	a_read_data: assert property (
		(state == ST_READ && done) |=> {data_hi[0], data_lo[0]} == mem[nvm_address])
		else $error("read word not in data pair 0");
endmodule

// file: core/nvmc_pkg.sv
package nvmc_pkg;
	// ==========================================================
	// Storage geometry.
	localparam int ADDR_W = 5;
	localparam int WORD_W = 15;
	localparam int DEPTH = 32;
	localparam int PAGE_BITS = 4;
	localparam int UNIT_BITS = 2;
	localparam int NUM_DATA = 4;
	localparam int LO_W = 8;
	localparam int HI_W = 7;

	// ==========================================================
	// Register map, byte addresses on the APB bus.
	localparam int PADDR_W = 8;
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_ADDRESS = 8'h04;
	localparam logic [7:0] OFF_DATA_BASE = 8'h08;
	localparam logic [7:0] DATA_STRIDE = 8'h08;
	localparam logic [7:0] DATA_HI_STEP = 8'h04;

	// ==========================================================
	// Control register fields and reset value.
	localparam int BIT_SEL_HI = 7;
	localparam int BIT_SEL_LO = 6;
	localparam int BIT_ERASE_ARM = 5;
	localparam int BIT_ERASE_START = 4;
	localparam int BIT_WRITE_ARM = 3;
	localparam int BIT_WRITE_START = 2;
	localparam int BIT_READ_ARM = 1;
	localparam int BIT_READ_START = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ==========================================================
	// Timing; the slow tick stands in for the sub clock.
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int PROG_BASE_MS = 2;
	localparam int TICKS_W = 5;
	localparam int READ_TIME_NS = 10;
	localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ERASE = 2'b01,
		ST_WRITE = 2'b10,
		ST_READ = 2'b11
	} nvmc_state_type;
endpackage

// file: core/nvmc_tick_div.sv
`timescale 1ns/1ps
module nvmc_tick_div #(
	parameter int CYCLES = 200000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;

	// ==========================================================
	// Restart aligns the first tick with the launch of a cycle.
	always_comb begin
		tick = (count == CW'(CYCLES - 1)) && !restart;
		next_count = count + CW'(1);
		if (restart || tick) begin
			next_count = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// file: core/nvmc_timer.sv
`timescale 1ns/1ps
module nvmc_timer #(
	parameter int W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic step,
	output logic done
);
	logic [W-1:0] remaining;
	logic [W-1:0] next_remaining;

	// ==========================================================
	// Down counter; done pulses on the step that uses up the last unit.
	always_comb begin
		done = (remaining == W'(1)) && step && !load;
		next_remaining = remaining;
		if (load) begin
			next_remaining = load_value;
		end else if (step && remaining != '0) begin
			next_remaining = remaining - W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remaining <= '0;
		end else begin
			remaining <= next_remaining;
		end
	end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import nvmc_pkg::*;
	// ==========================================================
	// Short tick so a 16 ms cycle takes only 64 clocks.
	localparam int TICK = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_stall;
	logic [PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r_data, seed;
	logic r_err;
	int r_wait, fails, n_tests;
	logic [14:0] model [DEPTH];

	nvmc_ctrl #(.TICK_LEN(TICK)) u_nvmc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall));

	// ==========================================================
	// Clock, and a watchdog sized well above the longest sequence.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#300000;
		fails++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] lo_a(input int i);
		return OFF_DATA_BASE + DATA_STRIDE * 8'(i);
	endfunction

	// ==========================================================
	// One APB transfer; wait states are counted, since a stalled bus is the stall.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		r_wait = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			r_wait++;
			if (r_wait == 1) check(cpu_stall, 1'b1);
			if (r_wait > 2000) begin
				fails++;
				wrap_up();
			end
			@(posedge pclk);
		end
		if (r_wait > 0) check(cpu_stall, 1'b0);
		r_data = prdata;
		r_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Arm, start, then read control back; d is the expected cycle length, 0 if refused.
	// With gap set, another transfer sits between arm and start, which must refuse an erase or write start.
	// No interrupt source exists on this bench, so arm and start are never split by one.
	task automatic ctl_seq(input logic [7:0] arm, input logic [7:0] start,
		input logic [7:0] after, input int d, input logic gap);
		apb(1'b1, OFF_CONTROL, {24'h0, arm});
		if (gap) apb(1'b0, OFF_ADDRESS, 32'h0);
		apb(1'b1, OFF_CONTROL, {24'h0, start});
		apb(1'b0, OFF_CONTROL, 32'h0);
		if (d == 0) begin
			check(r_wait, 0);
		end else begin
			check(32'(r_wait >= d - 1 && r_wait <= d + 3), 32'h1);
		end
		check(r_data, {24'h0, after});
	endtask

	task automatic erase_page(input logic p, input logic [1:0] sel);
		apb(1'b1, OFF_ADDRESS, {27'h0, p, 4'(xs())});
		apb(1'b1, OFF_CONTROL, {24'h0, sel, 6'h0});
		ctl_seq({sel, 6'h20}, {sel, 6'h30}, {sel, 6'h0}, (2 << sel) * TICK, 1'b0);
		for (int k = 0; k < 16; k++) model[{p, 4'(k)}] = 15'h0;
	endtask

	task automatic write_unit(input logic [2:0] u, input logic [1:0] sel);
		logic [14:0] w;
		for (int i = 0; i < NUM_DATA; i++) begin
			w = 15'(xs());
			model[{u, 2'(i)}] = w;
			apb(1'b1, lo_a(i), {24'h0, w[7:0]});
			apb(1'b1, lo_a(i) + DATA_HI_STEP, {25'h0, w[14:8]});
		end
		apb(1'b1, OFF_ADDRESS, {27'h0, u, 2'(xs())});
		apb(1'b1, OFF_CONTROL, {24'h0, sel, 6'h0});
		ctl_seq({sel, 6'h08}, {sel, 6'h0c}, {sel, 6'h0}, (2 << sel) * TICK, 1'b0);
	endtask

	// Read arm is set once; each read relaunches with arm kept high.
	task automatic read_all();
		logic [31:0] lo;
		apb(1'b1, OFF_CONTROL, 32'h02);
		for (int a = 0; a < DEPTH; a++) begin
			apb(1'b1, OFF_ADDRESS, 32'(a));
			apb(1'b1, OFF_CONTROL, 32'h03);
			apb(1'b0, OFF_CONTROL, 32'h0);
			check(32'(r_wait > 0), 32'h1);
			check(r_data, 32'h02);
			apb(1'b0, lo_a(0), 32'h0);
			lo = r_data;
			apb(1'b0, lo_a(0) + DATA_HI_STEP, 32'h0);
			check({r_data[16:0], lo[7:0]}, {17'h0, model[a]});
		end
	endtask

	// ==========================================================
	// Main sequence: reset values, erase, write and read traffic, then refusals and a last erase and read.
	initial begin
		seed = 32'd56365;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CONTROL, 32'h0);
		check(r_data, {24'h0, CONTROL_RESET});
		for (int i = 0; i < 2 * NUM_DATA + 1; i++) begin
			apb(1'b0, OFF_ADDRESS + 8'(4 * i), 32'h0);
			check(r_data, 32'h0);
		end
		apb(1'b1, 8'h40, 32'hff);
		apb(1'b0, 8'h40, 32'h0);
		check({r_data[30:0], r_err}, 32'h1);
		erase_page(1'b0, 2'(xs()));
		erase_page(1'b1, 2'(xs()));
		for (int k = 0; k < 4; k++) write_unit(3'(xs()), 2'(k));
		read_all();
		// Starts without arm, and starts for write and erase that do not follow their arm directly.
		ctl_seq(8'h00, 8'h10, 8'h00, 0, 1'b0);
		ctl_seq(8'h00, 8'h04, 8'h00, 0, 1'b0);
		ctl_seq(8'h00, 8'h01, 8'h00, 0, 1'b0);
		ctl_seq(8'h08, 8'h0c, 8'h08, 0, 1'b1);
		ctl_seq(8'h20, 8'h30, 8'h20, 0, 1'b1);
		erase_page(1'(xs()), 2'b00);
		read_all();
		wrap_up();
	end
endmodule
